// [rtl/hwp_port.sv]
/*
  Host word handshake port: four-word mode request/acknowledge exchange
  and block mode multi-word writes and reads against the unit's RAM.
  Assumes host words arrive from another domain and are synchronised
  here; I_REFRESH is a one-cycle enable marking each I/O refresh; the
  block mode word stream comes from same-clock logic.
*/
// Behaviour
// - Bit 0 of word n+1 picks direction: 0 read, 1 write.
// - Write: store word n at address, then raise acknowledge flag.
// - Device clears acknowledge once request returns low.
// - Read: capture address, then raise acknowledge flag.
// - Read: fetch word, show in word n+2, raise data-ready bit 7.
// - Device clears data-ready once read-taken is set.
// - Single-word block write loads read pointer at address 12.
// - Read pointer holds until next single-word write or reset.
// - Block write above one word: first word is start address, rest written to RAM after staging.
// - Whole block validated; any error stores none of it.
// - Conversion data live at addresses 02..08 via block write.
// - New parameters act only on parameter update bit.
// - A block transfer carries at most 255 words.
// - Parameter update bit is bit 5 of output word n.
`timescale 1ns/100ps
`include "hwp_params.svh"
module hwp_port (
  input  wire logic              I_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_FOUR_WORD,
  input  wire logic              I_REFRESH,
  input  wire hwp_pkg::hwp_word_t I_OUT_N,
  input  wire hwp_pkg::hwp_word_t I_OUT_N1,
  output hwp_pkg::hwp_word_t     O_IN_N2,
  output hwp_pkg::hwp_word_t     O_IN_N3,
  output hwp_pkg::hwp_word_t     O_IN_N1,
  input  wire logic              I_BLK_START,
  input  wire logic              I_BLK_WRITE,
  input  wire hwp_pkg::hwp_cnt_t I_BLK_COUNT,
  input  wire logic              I_BLK_VALID,
  input  wire hwp_pkg::hwp_word_t I_BLK_DATA,
  input  wire logic              I_BLK_ERR,
  output logic                   O_BLK_READY,
  output logic                   O_BLK_RVALID,
  output hwp_pkg::hwp_word_t     O_BLK_RDATA,
  output logic                   O_BLK_DONE,
  output logic                   O_BLK_REJECT,
  output logic                   O_PARAM_APPLY
);
  import hwp_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_FOUR  = 6'b00_0010,
    ST_FETCH = 6'b00_0100,
    ST_BWR   = 6'b00_1000,
    ST_BCOM  = 6'b01_0000,
    ST_BRD   = 6'b10_0000
  } hwp_state_e;

  typedef struct packed {
    hwp_word_t  s1_n, s2_n, s1_n1, s2_n1;
    hwp_state_e st;
    logic       ack, rdy, fetch_wait, wr_done, pupd_prev, apply;
    hwp_adr_t   adr;
    hwp_adr_t   rdptr;
    hwp_word_t  rword;
    hwp_cnt_t   cnt, idx;
    logic       bad, rvalid, done, reject;
    hwp_adr_t   base;
  } hwp_state_s;

  hwp_state_s q, d;
  hwp_ram_if  ram ();

  hwp_ram #(.DEPTH(`HWP_RAM_DEPTH)) u_ram (
    .i_clk (I_CLK),
    .bus   (ram)
  );

  // Block write staging: words held until the whole block checks out
  hwp_word_t stage_q [`HWP_RAM_DEPTH];
  logic      stage_we;
  hwp_word_t stage_rd;
  always_ff @(posedge I_CLK) begin
    if (stage_we) begin
      stage_q[q.idx[7:0]] <= I_BLK_DATA;
    end
  end
  assign stage_rd = stage_q[q.idx[7:0]];

  always_comb begin
    d        = q;
    stage_we = 1'b0;
    ram.we   = 1'b0;
    ram.wadr = q.adr;
    ram.wdat = q.s2_n;
    ram.radr = q.adr;
    d.s1_n   = I_OUT_N;
    d.s2_n   = q.s1_n;
    d.s1_n1  = I_OUT_N1;
    d.s2_n1  = q.s1_n1;
    d.rvalid = 1'b0;
    d.done   = 1'b0;
    d.reject = 1'b0;
    d.apply  = 1'b0;
    d.wr_done = 1'b1;
    d.pupd_prev = q.s2_n[`HWP_BIT_PUPD];
    if (q.s2_n[`HWP_BIT_PUPD] && !q.pupd_prev) begin
      d.apply = 1'b1;
    end
    if (I_REFRESH && q.ack && !q.s2_n1[`HWP_BIT_REQ]) begin
      d.ack = 1'b0;
    end
    if (I_REFRESH && q.rdy && q.s2_n1[`HWP_BIT_TAKEN]) begin
      d.rdy = 1'b0;
    end
    case (q.st)
      ST_IDLE: begin
        if (I_FOUR_WORD && I_REFRESH && q.s2_n1[`HWP_BIT_REQ]
            && !q.ack && !q.rdy && !q.fetch_wait) begin
          d.adr = q.s2_n1[`HWP_DW-1:`HWP_ADR_LSB];
          d.st  = ST_FOUR;
        end else if (!I_FOUR_WORD && I_BLK_START) begin
          d.cnt = (I_BLK_COUNT > `HWP_MAX_WORDS) ? `HWP_MAX_WORDS
                                                 : I_BLK_COUNT;
          d.idx = `HWP_RST_CNT;
          d.bad = 1'b0;
          if (I_BLK_COUNT == `HWP_RST_CNT) begin
            d.done = 1'b1;
          end else if (I_BLK_WRITE) begin
            d.st = ST_BWR;
          end else begin
            d.adr = q.rdptr;
            d.st  = ST_BRD;
          end
        end
      end
      ST_FOUR: begin
        if (q.s2_n1[`HWP_BIT_DIR]) begin
          ram.we   = 1'b1;
          ram.wadr = q.adr;
          ram.wdat = q.s2_n;
        end else begin
          d.fetch_wait = 1'b1;
        end
        d.ack = 1'b1;
        d.st  = q.s2_n1[`HWP_BIT_DIR] ? ST_IDLE : ST_FETCH;
      end
      ST_FETCH: begin
        d.st = ST_IDLE; // RAM read data registered in this cycle
      end
      ST_BWR: begin
        if (I_BLK_VALID) begin
          stage_we = 1'b1;
          if (I_BLK_ERR) begin
            d.bad = 1'b1;
          end
          d.idx = q.idx + `HWP_ONE_WORD;
          if (q.idx + `HWP_ONE_WORD == q.cnt) begin
            d.idx = `HWP_RST_CNT;
            d.st  = ST_BCOM;
          end
        end
      end
      ST_BCOM: begin
        if (q.bad || I_BLK_ERR && I_BLK_VALID) begin
          d.reject = 1'b1;
          d.st     = ST_IDLE;
        end else if (q.cnt == `HWP_ONE_WORD) begin
          d.rdptr = stage_rd[`HWP_AW-1:0];
          d.done  = 1'b1;
          d.st    = ST_IDLE;
        end else if (q.idx == `HWP_RST_CNT) begin
          d.base = stage_rd[`HWP_AW-1:0];
          d.idx  = `HWP_ONE_WORD;
        end else begin
          ram.we   = 1'b1;
          ram.wadr = q.base + q.idx[`HWP_AW-1:0] - 8'h01;
          ram.wdat = stage_rd;
          d.idx    = q.idx + `HWP_ONE_WORD;
          if (q.idx + `HWP_ONE_WORD == q.cnt) begin
            d.done = 1'b1;
            d.st   = ST_IDLE;
          end
        end
      end
      ST_BRD: begin
        ram.radr = q.adr;
        if (q.idx != `HWP_RST_CNT) begin
          d.rvalid = 1'b1;
        end
        if (q.idx == q.cnt) begin
          d.done = 1'b1;
          d.st   = ST_IDLE;
        end else begin
          d.adr = q.adr + 8'h01;
          d.idx = q.idx + `HWP_ONE_WORD;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (q.fetch_wait && q.st == ST_IDLE) begin
      d.rword      = ram.rdat;
      d.rdy        = 1'b1;
      d.fetch_wait = 1'b0;
    end
    if (q.st == ST_BRD && q.idx != `HWP_RST_CNT) begin
      d.rword = ram.rdat;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.rdptr <= `HWP_RST_ADR;
      q.rword <= `HWP_RST_WORD;
    end else begin
      q <= d;
    end
  end

  assign O_BLK_READY   = (q.st == ST_BWR);
  assign O_BLK_RVALID  = q.rvalid;
  assign O_BLK_RDATA   = q.rword;
  assign O_BLK_DONE    = q.done;
  assign O_BLK_REJECT  = q.reject;
  assign O_PARAM_APPLY = q.apply;
  assign O_IN_N2       = q.rword;
  always_comb begin
    O_IN_N3 = `HWP_RST_WORD;
    O_IN_N3[`HWP_BIT_ACK] = q.ack;
    O_IN_N3[`HWP_BIT_RDY] = q.rdy;
    O_IN_N1 = `HWP_RST_WORD;
    O_IN_N1[`HWP_BIT_WRDONE] = q.wr_done;
  end
endmodule : hwp_port

// [rtl/hwp_params.svh]
/*
  Constants of the host word handshake port: bit positions, addresses,
  widths, counts and reset values.
  Assumes inclusion by bare name from design files.
*/
`ifndef HWP_PARAMS_SVH
`define HWP_PARAMS_SVH
`define HWP_DW            16
`define HWP_AW            8
`define HWP_RAM_DEPTH     256
`define HWP_ADR_RDPTR     8'h0C
`define HWP_ADR_CONV_LO   8'h02
`define HWP_ADR_CONV_HI   8'h08
`define HWP_MAX_WORDS     9'h0FF
`define HWP_BIT_DIR       0
`define HWP_BIT_REQ       6
`define HWP_BIT_TAKEN     7
`define HWP_BIT_ACK       6
`define HWP_BIT_RDY       7
`define HWP_BIT_WRDONE    2
`define HWP_BIT_PUPD      5
`define HWP_ADR_LSB       8
`define HWP_RST_WORD      16'h0000
`define HWP_RST_ADR       8'h00
`define HWP_RST_CNT       9'h000
`define HWP_ONE_WORD      9'h001
`endif

// [rtl/hwp_pkg.sv]
/*
  Types of the host word handshake port.
  Assumes hwp_params.svh on the include path.
*/
`include "hwp_params.svh"
package hwp_pkg;
  typedef logic [`HWP_DW-1:0] hwp_word_t;
  typedef logic [`HWP_AW-1:0] hwp_adr_t;
  typedef logic [8:0]         hwp_cnt_t;
endpackage : hwp_pkg

// [rtl/hwp_ram_if.sv]
/*
  Carrier between the port controller and its word memory.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface hwp_ram_if;
  import hwp_pkg::*;
  logic      we;
  hwp_adr_t  wadr;
  hwp_word_t wdat;
  hwp_adr_t  radr;
  hwp_word_t rdat;
  modport ctl (output we, output wadr, output wdat, output radr,
               input rdat);
  modport mem (input we, input wadr, input wdat, input radr,
               output rdat);
endinterface : hwp_ram_if

// [rtl/hwp_ram.sv]
/*
  Word memory of the unit with registered read data.
  Assumes a synchronous single clock; contents are not reset.
*/
`timescale 1ns/100ps
`include "hwp_params.svh"
module hwp_ram #(
  parameter int DEPTH = `HWP_RAM_DEPTH
) (
  input  wire logic i_clk,
  hwp_ram_if.mem    bus
);
  import hwp_pkg::*;
  hwp_word_t mem_q [DEPTH];
  hwp_word_t rdat_q;
  always_ff @(posedge i_clk) begin
    if (bus.we) begin
      mem_q[bus.wadr] <= bus.wdat;
    end
    rdat_q <= mem_q[bus.radr];
  end
  assign bus.rdat = rdat_q;
endmodule : hwp_ram

// [tb/hwp_port_properties.sv]
/* Port checker for hwp_port. Assumes a bind from the bench top. */
`timescale 1ns/100ps
module hwp_port_properties (
  input wire logic               I_CLK,
  input wire logic               I_SYS_RST,
  input wire logic               I_REFRESH,
  input wire hwp_pkg::hwp_word_t I_OUT_N,
  input wire hwp_pkg::hwp_word_t O_IN_N1,
  input wire hwp_pkg::hwp_word_t O_IN_N2,
  input wire hwp_pkg::hwp_word_t O_IN_N3,
  input wire logic               O_PARAM_APPLY
);
  import hwp_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_ack_up; $rose(O_IN_N3[6]); endsequence
  sequence s_rdy_up; $rose(O_IN_N3[7]); endsequence
  property p_ack_at; s_ack_up |-> $past(I_REFRESH, 2); endproperty
  property p_ack_idle; s_ack_up |-> !$past(O_IN_N3[7]); endproperty
  property p_ack_off; $fell(O_IN_N3[6]) |-> $past(I_REFRESH); endproperty
  property p_rdy_at; s_rdy_up |-> $past(I_REFRESH, 4); endproperty
  property p_rdy_off; $fell(O_IN_N3[7]) |-> $past(I_REFRESH); endproperty
  property p_rd_hold;
    O_IN_N3[7] && $past(O_IN_N3[7]) |-> $stable(O_IN_N2);
  endproperty
  property p_apply;
    O_PARAM_APPLY |-> $past(I_OUT_N[5], 3) && !$past(I_OUT_N[5], 4);
  endproperty
  property p_wr_done; !$past(I_SYS_RST) |-> O_IN_N1 == 16'h0004; endproperty
  a_ack_at: assert property (p_ack_at)
    else $error("ack off schedule");
  a_ack_idle: assert property (p_ack_idle)
    else $error("ack while ready set");
  a_ack_off: assert property (p_ack_off)
    else $error("ack cleared off refresh");
  a_rdy_at: assert property (p_rdy_at)
    else $error("ready off schedule");
  a_rdy_off: assert property (p_rdy_off)
    else $error("ready cleared off refresh");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read word moved");
  a_apply: assert property (p_apply)
    else $error("apply without rising update bit");
  a_wr_done: assert property (p_wr_done)
    else $error("write complete wrong");
endmodule : hwp_port_properties

// [tb/hwp_host_model.sv]
/* Host model: one four-word transfer per go. Assumes refresh sampling. */
`timescale 1ns/100ps
module hwp_host_model (
  input  wire logic               clk,
  input  wire logic               go,
  input  wire logic               wr,
  input  wire hwp_pkg::hwp_adr_t  adr,
  input  wire hwp_pkg::hwp_word_t wdat,
  input  wire hwp_pkg::hwp_word_t in_n3,
  input  wire hwp_pkg::hwp_word_t in_n2,
  output hwp_pkg::hwp_word_t      out_n = '0,
  output hwp_pkg::hwp_word_t      out_n1 = '0,
  output hwp_pkg::hwp_word_t      rdat = '0,
  output logic                    busy
);
  int st = 0;
  assign busy = (st != 0);
  always @(posedge clk) begin
    case (st)
      0: begin
        out_n <= wdat;
        if (go) begin
          out_n1 <= {adr, 7'h00, wr};
          st <= 1;
        end
      end
      1: begin
        out_n1[6] <= 1'b1;
        st <= 2;
      end
      2: if (in_n3[6]) begin
        out_n1[6] <= 1'b0;
        st <= wr ? 5 : 3;
      end
      3: if (in_n3[7]) begin
        rdat <= in_n2;
        out_n1[7] <= 1'b1;
        st <= 4;
      end
      4: if (!in_n3[7]) begin
        out_n1[7] <= 1'b0;
        st <= 5;
      end
      default: if (!in_n3[6]) st <= 0;
    endcase
  end
endmodule : hwp_host_model

// [tb/test_hwp_port.sv]
/* Bench for hwp_port. Assumes the rtl header on the include path. */
`timescale 1ns/100ps
module test_hwp_port;
  import hwp_pkg::*;
  typedef struct { hwp_adr_t a; hwp_word_t d; } hwp_row_s;
  logic      I_CLK = 0, I_SYS_RST = 1, I_FOUR_WORD = 1, I_REFRESH = 0;
  logic      I_BLK_START = 0, I_BLK_WRITE = 0, I_BLK_VALID = 0;
  logic      I_BLK_ERR = 0, go = 0, wr = 0, seen, busy;
  logic      O_BLK_READY, O_BLK_RVALID, O_BLK_DONE, O_BLK_REJECT;
  logic      O_PARAM_APPLY;
  logic [1:0] rc = '0;
  hwp_cnt_t  I_BLK_COUNT = '0;
  hwp_adr_t  adr = '0;
  hwp_word_t I_BLK_DATA = '0, wdat = '0, rdat, I_OUT_N, I_OUT_N1;
  hwp_word_t O_IN_N1, O_IN_N2, O_IN_N3, O_BLK_RDATA;
  int        n_fail = 0, num_checks = 0;
  hwp_row_s  rows [4] = '{'{8'h03, 16'h1234}, '{8'h04, 16'hABCD},
                         '{8'h08, 16'h00FF}, '{8'hFF, 16'h8001}};
  hwp_port uut (.*);
  hwp_host_model u_host (.clk(I_CLK), .go(go), .wr(wr), .adr(adr),
    .wdat(wdat), .in_n3(O_IN_N3), .in_n2(O_IN_N2), .out_n(I_OUT_N),
    .out_n1(I_OUT_N1), .rdat(rdat), .busy(busy));
  initial forever #10 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    rc <= rc + 2'd1;
    I_REFRESH <= (rc == 2'd3);
  end
  task automatic chk(input string nm, input hwp_word_t got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic fw(input logic w, input hwp_adr_t a, input hwp_word_t d);
    @(posedge I_CLK);
    go <= 1'b1;
    wr <= w;
    adr <= a;
    wdat <= d;
    @(posedge I_CLK);
    go <= 1'b0;
    do @(negedge I_CLK); while (busy);
    if (!w) chk("word", rdat, d);
  endtask : fw
  task automatic blk(input logic w, input int n, input hwp_word_t d [4],
                     input logic [3:0] e, input logic rej);
    @(posedge I_CLK);
    I_BLK_START <= 1'b1;
    I_BLK_WRITE <= w;
    I_BLK_COUNT <= hwp_cnt_t'(n);
    @(posedge I_CLK);
    I_BLK_START <= 1'b0;
    for (int i = 0; i < n; i++)
      if (w) begin
        I_BLK_VALID <= 1'b1;
        I_BLK_DATA <= d[i];
        I_BLK_ERR <= e[i];
        do @(negedge I_CLK); while (O_BLK_READY !== 1'b1);
        @(posedge I_CLK);
      end else begin
        do @(negedge I_CLK); while (O_BLK_RVALID !== 1'b1);
        chk("rdata", O_BLK_RDATA, d[i]);
      end
    if (!w) chk("done", {15'h0, O_BLK_DONE}, 16'h0001);
    if (w) begin
      I_BLK_VALID <= 1'b0;
      do @(negedge I_CLK); while (!O_BLK_DONE && !O_BLK_REJECT);
    end
    chk("reject", {15'h0, O_BLK_REJECT}, {15'h0, rej});
  endtask : blk
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge I_CLK);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge I_CLK);
    @(negedge I_CLK);
    chk("n3", O_IN_N3, '0);
    repeat (10) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    repeat (4) @(negedge I_CLK);
    chk("n1", O_IN_N1, 16'h0004);
    $display("test reset done");
    foreach (rows[i]) fw(1'b1, rows[i].a, rows[i].d);
    foreach (rows[i]) fw(1'b0, rows[i].a, rows[i].d);
    $display("test table done");
    @(posedge I_CLK);
    I_FOUR_WORD <= 1'b0;
    blk(1, 1, '{16'h0003, '0, '0, '0}, 4'h0, 0);
    blk(0, 2, '{16'h1234, 16'hABCD, '0, '0}, 4'h0, 0);
    blk(1, 3, '{16'h0010, 16'h5A5A, 16'hC3C3, '0}, 4'h0, 0);
    blk(0, 1, '{16'h1234, '0, '0, '0}, 4'h0, 0);
    blk(1, 3, '{16'h0010, 16'h1111, 16'h2222, '0}, 4'h4, 1);
    @(posedge I_CLK);
    wdat <= 16'h0020;
    seen = 1'b0;
    repeat (8) begin
      @(negedge I_CLK);
      seen |= O_PARAM_APPLY;
    end
    chk("apply", {15'h0, seen}, 16'h0001);
    $display("test block done");
    @(posedge I_CLK);
    I_FOUR_WORD <= 1'b1;
    fw(1'b0, 8'h10, 16'h5A5A);
    fw(1'b0, 8'h11, 16'hC3C3);
    $display("test cross done");
    summarize();
  end
endmodule : test_hwp_port
bind hwp_port hwp_port_properties u_prop (.I_CLK(I_CLK),
  .I_SYS_RST(I_SYS_RST), .I_REFRESH(I_REFRESH), .I_OUT_N(I_OUT_N),
  .O_IN_N1(O_IN_N1), .O_IN_N2(O_IN_N2), .O_IN_N3(O_IN_N3),
  .O_PARAM_APPLY(O_PARAM_APPLY));
